// *** dtpc_consts.svh ***
// Constants of the dual timer block: register indexes, fields, resets.
// Included by the prescaler, bus slave and timer files; holds definitions only.
`ifndef DTPC_CONSTS_SVH
`define DTPC_CONSTS_SVH
// Register indexes; byte address is four times the index, plus 0x100 in the second plane
`define DTPC_IDX_T0CNT    6'h01
`define DTPC_IDX_FLAGS    6'h09
`define DTPC_IDX_T1LOW    6'h0a
`define DTPC_IDX_T1HIGH   6'h0b
`define DTPC_IDX_HOLD     6'h12
`define DTPC_IDX_T0MODE   6'h02
`define DTPC_IDX_T1MODE   6'h0c
`define DTPC_IDX_TKSEL    6'h0d
// Address bit that selects the second register plane
`define DTPC_PLANE_BIT    8
// Field positions
`define DTPC_F_T0FLAG     4
`define DTPC_F_T1FLAG     5
`define DTPC_F_T2CLR      4
`define DTPC_F_T1SET      3
`define DTPC_F_T1CLR      2
`define DTPC_F_T1HALT     1
`define DTPC_F_T0HALT     0
`define DTPC_F_CAPPOL     7
`define DTPC_F_T0CAP      6
`define DTPC_F_T0EDGE     5
`define DTPC_F_T0SRC      4
`define DTPC_F_T1CAP      1
`define DTPC_F_T1DIV      0
`define DTPC_F_T0TKS      6
// Reset values
`define DTPC_RST_HOLD     5'h10
`define DTPC_RST_T0MODE   8'h00
// Bus answers
`define DTPC_RESP_OKAY    2'h0
`define DTPC_RESP_SLVERR  2'h2
`endif

// *** dtpc_pkg.sv ***
// Types shared by the dual timer block.
// Constants live in dtpc_consts.svh.
package dtpc_pkg;
    typedef enum logic [1:0] {
        DTPC_RD_IDLE = 2'b01,
        DTPC_RD_RESP = 2'b10
    } dtpc_rd_state_e;
    typedef logic [6:0] dtpc_addr_t;
endpackage

// *** dtpc_reg_if.sv ***
// Register access carrier between bus slave and timer core.
// Assumes one clock; read data is combinational from the core.
`timescale 1ns/10ps
interface dtpc_reg_if;
    logic       wrEn;
    logic [6:0] wrAddr;
    logic [7:0] wrData;
    logic       wrHit;
    logic [6:0] rdAddr;
    logic [7:0] rdData;
    logic       rdHit;
    modport bus  (output wrEn, wrAddr, wrData, rdAddr, input wrHit, rdData, rdHit);
    modport core (input wrEn, wrAddr, wrData, rdAddr, output wrHit, rdData, rdHit);
endinterface

// *** dtpc_prescaler.sv ***
// Timer0 prescaler: source pick, edge pick, power-of-two divider.
// Pins are taken as synchronous to sys_clk.
`timescale 1ns/10ps
`include "dtpc_consts.svh"
module dtpc_prescaler (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       instrTick,
    input  wire logic       extPin,
    input  wire logic       sourceSel,
    input  wire logic       fallingEdge,
    input  wire logic [3:0] divCode,
    output logic            tick
);
    import dtpc_pkg::*;
    logic       pinPrev;
    logic       srcEvent;
    logic [7:0] cnt;
    logic [7:0] mask;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pinPrev <= 1'b0;
        end else begin
            pinPrev <= extPin;
        end
    end

    always_comb begin
        if (sourceSel) begin
            srcEvent = fallingEdge ? (pinPrev && !extPin) : (!pinPrev && extPin);
        end else begin
            srcEvent = instrTick;
        end
        if (divCode[3]) begin
            mask = 8'hff;
        end else begin
            mask = 8'hff >> (4'h8 - {1'b0, divCode[2:0]});
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 8'h00;
        end else if (srcEvent) begin
            cnt <= cnt + 8'h01;
        end
    end

    assign tick = srcEvent && ((cnt & mask) == mask);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_cpu_source_tick: assert property (tick && !sourceSel |-> instrTick)
        else $error("prescaler ticked off the instruction cycle");
    a_div_256_span: assert property (tick && divCode[3] |-> cnt == 8'hff)
        else $error("divide by 256 ticked early");
endmodule

// *** dtpc_axil_slave.sv ***
// AXI4-Lite slave front end for the dual timer registers.
// One write and one read at a time; 8-bit registers in low data lane.
`timescale 1ns/10ps
`include "dtpc_consts.svh"
module dtpc_axil_slave #(
    parameter int ADDR_W = 12
) (
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    dtpc_reg_if.bus                regs
);
    import dtpc_pkg::*;
    logic           awHeld;
    logic           wHeld;
    logic           awInRange;
    logic           arInRange;
    logic [6:0]     awSlot;
    logic [7:0]     wByte;
    logic           wLane;
    logic           writeGo;
    dtpc_rd_state_e rdState;

    // Bits above the two planes must be zero for a hit
    assign arInRange = (araddr >> (`DTPC_PLANE_BIT + 1)) == '0;
    assign awready   = !awHeld && !bvalid;
    assign wready    = !wHeld && !bvalid;
    assign writeGo   = awHeld && wHeld;
    assign arready   = rdState == DTPC_RD_IDLE;
    assign regs.rdAddr = {araddr[`DTPC_PLANE_BIT], araddr[7:2]};
    assign regs.wrAddr = awSlot;
    assign regs.wrData = wByte;
    assign regs.wrEn   = writeGo && wLane && awInRange;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld    <= 1'b0;
            awSlot    <= 7'h00;
            awInRange <= 1'b0;
        end else if (awvalid && awready) begin
            awHeld    <= 1'b1;
            awSlot    <= {awaddr[`DTPC_PLANE_BIT], awaddr[7:2]};
            awInRange <= (awaddr >> (`DTPC_PLANE_BIT + 1)) == '0;
        end else if (writeGo) begin
            awHeld    <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wHeld <= 1'b0;
            wByte <= 8'h00;
            wLane <= 1'b0;
        end else if (wvalid && wready) begin
            wHeld <= 1'b1;
            wByte <= wdata[7:0];
            wLane <= wstrb[0];
        end else if (writeGo) begin
            wHeld <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bvalid <= 1'b0;
            bresp  <= `DTPC_RESP_OKAY;
        end else if (writeGo) begin
            bvalid <= 1'b1;
            bresp  <= (awInRange && regs.wrHit) ? `DTPC_RESP_OKAY : `DTPC_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdState <= DTPC_RD_IDLE;
            rdata   <= 32'h0000_0000;
            rresp   <= `DTPC_RESP_OKAY;
        end else begin
            unique case (rdState)
                DTPC_RD_IDLE: begin
                    if (arvalid) begin
                        rdState <= DTPC_RD_RESP;
                        rdata   <= {24'h00_0000, arInRange ? regs.rdData : 8'h00};
                        rresp   <= (arInRange && regs.rdHit) ? `DTPC_RESP_OKAY
                                                             : `DTPC_RESP_SLVERR;
                    end
                end
                DTPC_RD_RESP: begin
                    if (rready) begin
                        rdState <= DTPC_RD_IDLE;
                    end
                end
            endcase
        end
    end
    assign rvalid = rdState == DTPC_RD_RESP;
endmodule

// *** dtpc_timers.sv ***
// Dual timer block top: Timer0 with prescaler and capture, Timer1 with
// reload and capture, Timer2 hold-clear, and their register file.
// Assumes one 125 MHz clock; pins are synchronous to it.
// Function
// - Low byte reads count, writes reload
// - High byte reads count, writes reload
// - Timer2 zeroed and held; held after reset
// - Timer1 force-set holds all ones
// - Timer1 hold-clear keeps count zero
// - Timer1 halt freezes count
// - Timer0 halt freezes count
// - Capture counts on selected pin level
// - Mode bit picks prescaler or capture
// - Edge bit picks rising or falling
// - Source bit picks instruction cycle or pin
// - Divider is power of two, max 256
// - Timer0 overflow sets flag; zero clears
// - Timer1 overflow sets flag; zero clears
// - Timer1 capture measures pin period
// - Timer1 divider: full or half clock
`timescale 1ns/10ps
`include "dtpc_consts.svh"
module dtpc_timers #(
    parameter int ADDR_W = 12
) (
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              externalCountPin,
    input  wire logic              touchKeyOscillator,
    input  wire logic              capturePin,
    output logic                   timer0OverflowFlag,
    output logic                   timer1OverflowFlag,
    output logic [7:0]             timer2Count,
    output logic [15:0]            timer1Period
);
    import dtpc_pkg::*;
    dtpc_reg_if regs ();

    logic [4:0]  holdCtl;
    logic [7:0]  t0Mode;
    logic [1:0]  t1Mode;
    logic        touchSel;
    logic [7:0]  t0Count;
    logic [15:0] t1Count;
    logic [15:0] t1Reload;
    logic        instrTick;
    logic        t0PrescTick;
    logic        t0Event;
    logic        t0Over;
    logic        t1Tick;
    logic        t1Over;
    logic        t1Run;
    logic        capPrev;
    logic        capEdge;
    logic        levelOk;
    logic        flagWrite;
    logic        wrF;
    logic        wrR;
    logic [5:0]  wrIdx;

    dtpc_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .regs    (regs.bus)
    );

    // Instruction cycle is every second clock
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            instrTick <= 1'b0;
        end else begin
            instrTick <= !instrTick;
        end
    end

    // Register writes
    assign wrIdx = regs.wrAddr[5:0];
    assign wrF   = regs.wrEn && !regs.wrAddr[6];
    assign wrR   = regs.wrEn && regs.wrAddr[6];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            holdCtl <= `DTPC_RST_HOLD;
        end else if (wrF && wrIdx == `DTPC_IDX_HOLD) begin
            holdCtl <= regs.wrData[4:0];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            t0Mode   <= `DTPC_RST_T0MODE;
            t1Mode   <= 2'h0;
            touchSel <= 1'b0;
        end else if (wrR) begin
            if (wrIdx == `DTPC_IDX_T0MODE) begin
                t0Mode <= regs.wrData;
            end
            if (wrIdx == `DTPC_IDX_T1MODE) begin
                t1Mode <= regs.wrData[1:0];
            end
            if (wrIdx == `DTPC_IDX_TKSEL) begin
                touchSel <= regs.wrData[`DTPC_F_T0TKS];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            t1Reload <= 16'h0000;
        end else if (wrF && wrIdx == `DTPC_IDX_T1LOW) begin
            t1Reload[7:0] <= regs.wrData;
        end else if (wrF && wrIdx == `DTPC_IDX_T1HIGH) begin
            t1Reload[15:8] <= regs.wrData;
        end
    end

    // Register reads; write-only registers read as zero
    always_comb begin
        regs.rdData = 8'h00;
        regs.rdHit  = 1'b1;
        if (!regs.rdAddr[6]) begin
            unique case (regs.rdAddr[5:0])
                `DTPC_IDX_T0CNT:  regs.rdData = t0Count;
                `DTPC_IDX_FLAGS:  regs.rdData = {2'h0, timer1OverflowFlag,
                                                 timer0OverflowFlag, 4'h0};
                `DTPC_IDX_T1LOW:  regs.rdData = t1Count[7:0];
                `DTPC_IDX_T1HIGH: regs.rdData = t1Count[15:8];
                `DTPC_IDX_HOLD:   regs.rdData = {3'h0, holdCtl};
                default:          regs.rdHit  = 1'b0;
            endcase
        end else begin
            unique case (regs.rdAddr[5:0])
                `DTPC_IDX_T0MODE, `DTPC_IDX_T1MODE, `DTPC_IDX_TKSEL: regs.rdHit = 1'b1;
                default: regs.rdHit = 1'b0;
            endcase
        end
    end

    always_comb begin
        unique case (regs.wrAddr)
            {1'b0, `DTPC_IDX_T0CNT}, {1'b0, `DTPC_IDX_FLAGS}, {1'b0, `DTPC_IDX_T1LOW},
            {1'b0, `DTPC_IDX_T1HIGH}, {1'b0, `DTPC_IDX_HOLD}, {1'b1, `DTPC_IDX_T0MODE},
            {1'b1, `DTPC_IDX_T1MODE}, {1'b1, `DTPC_IDX_TKSEL}: regs.wrHit = 1'b1;
            default: regs.wrHit = 1'b0;
        endcase
    end

    // Timer0
    dtpc_prescaler u_presc (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .instrTick   (instrTick),
        .extPin      (touchSel ? touchKeyOscillator : externalCountPin),
        .sourceSel   (t0Mode[`DTPC_F_T0SRC]),
        .fallingEdge (t0Mode[`DTPC_F_T0EDGE]),
        .divCode     (t0Mode[3:0]),
        .tick        (t0PrescTick)
    );

    assign levelOk = capturePin ^ t0Mode[`DTPC_F_CAPPOL];
    // Capture mode counts instruction cycles while the pin sits at level
    assign t0Event = t0Mode[`DTPC_F_T0CAP] ? (instrTick && levelOk) : t0PrescTick;
    assign t0Over  = t0Event && !holdCtl[`DTPC_F_T0HALT] && t0Count == 8'hff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            t0Count <= 8'h00;
        end else if (wrF && wrIdx == `DTPC_IDX_T0CNT) begin
            t0Count <= regs.wrData;
        end else if (t0Event && !holdCtl[`DTPC_F_T0HALT]) begin
            t0Count <= t0Count + 8'h01;
        end
    end

    // Flags: a set in the clearing cycle wins
    assign flagWrite = wrF && wrIdx == `DTPC_IDX_FLAGS;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer0OverflowFlag <= 1'b0;
            timer1OverflowFlag <= 1'b0;
        end else begin
            timer0OverflowFlag <= t0Over || (timer0OverflowFlag &&
                !(flagWrite && !regs.wrData[`DTPC_F_T0FLAG]));
            timer1OverflowFlag <= t1Over || (timer1OverflowFlag &&
                !(flagWrite && !regs.wrData[`DTPC_F_T1FLAG]));
        end
    end

    // Timer1
    assign t1Tick  = t1Mode[`DTPC_F_T1DIV] ? 1'b1 : instrTick;
    assign capEdge = t1Mode[`DTPC_F_T1CAP] && capturePin && !capPrev;
    assign t1Run   = holdCtl[`DTPC_F_T1SET:`DTPC_F_T1HALT] == 3'b000;
    assign t1Over  = t1Run && !capEdge && t1Tick && t1Count == 16'hffff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            capPrev <= 1'b0;
        end else begin
            capPrev <= capturePin;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            t1Count <= 16'h0000;
        end else if (holdCtl[`DTPC_F_T1SET]) begin
            t1Count <= 16'hffff;
        end else if (holdCtl[`DTPC_F_T1CLR]) begin
            t1Count <= 16'h0000;
        end else if (holdCtl[`DTPC_F_T1HALT]) begin
            t1Count <= t1Count;
        end else if (capEdge) begin
            t1Count <= t1Reload;
        end else if (t1Tick) begin
            t1Count <= (t1Count == 16'hffff) ? t1Reload : t1Count + 16'h0001;
        end
    end

    // Period is the count reached between two rising capture edges
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer1Period <= 16'h0000;
        end else if (capEdge && t1Run) begin
            timer1Period <= t1Count;
        end
    end

    // Timer2
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer2Count <= 8'h00;
        end else if (holdCtl[`DTPC_F_T2CLR]) begin
            timer2Count <= 8'h00;
        end else if (instrTick) begin
            timer2Count <= timer2Count + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_t1_wraps;
        t1Run && !capEdge && t1Tick && t1Count == 16'hffff;
    endsequence
    a_t2_hold_zero: assert property (holdCtl[`DTPC_F_T2CLR] |=> timer2Count == 8'h00)
        else $error("timer2 not held at zero");
    a_t1_force_set: assert property (holdCtl[`DTPC_F_T1SET] |=> t1Count == 16'hffff)
        else $error("timer1 force-set not all ones");
    a_t1_clear_hold: assert property (holdCtl[`DTPC_F_T1CLR] && !holdCtl[`DTPC_F_T1SET]
        |=> t1Count == 16'h0000)
        else $error("timer1 not held at zero");
    a_t1_halt_keep: assert property (t1Run == 1'b0 && holdCtl[`DTPC_F_T1HALT]
        && holdCtl[`DTPC_F_T1SET:`DTPC_F_T1CLR] == 2'b00 |=> $stable(t1Count))
        else $error("timer1 moved while halted");
    a_t0_halt_keep: assert property (holdCtl[`DTPC_F_T0HALT] && !(wrF && wrIdx ==
        `DTPC_IDX_T0CNT) |=> $stable(t0Count))
        else $error("timer0 moved while halted");
    a_t1_reload_wrap: assert property (s_t1_wraps |=> t1Count == $past(t1Reload))
        else $error("timer1 did not reload on overflow");
    a_t0_flag_set: assert property (t0Over |=> timer0OverflowFlag)
        else $error("timer0 flag lost");
    a_t1_flag_set: assert property (s_t1_wraps |=> timer1OverflowFlag)
        else $error("timer1 flag lost");
    a_t1_low_read: assert property (!regs.rdAddr[6] && regs.rdAddr[5:0] ==
        `DTPC_IDX_T1LOW |-> regs.rdData == t1Count[7:0])
        else $error("low byte read not live count");
    a_t0_capture_level: assert property (t0Mode[`DTPC_F_T0CAP] && t0Event |->
        capturePin != t0Mode[`DTPC_F_CAPPOL])
        else $error("timer0 captured at wrong level");
endmodule

// *** dual_timer_prescale_capture_tb.sv ***
// Self-checking bench for the dual timer block, driven over AXI4-Lite.
// Assumes one 125 MHz clock; all pins are driven in step with it.
`timescale 1ns/10ps
module dual_timer_prescale_capture_tb;
    logic        sys_clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, t0Flag, t1Flag;
    logic        extPin, tkOsc, capPin;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v0, v1;
    logic [1:0]  bresp, rresp;
    logic [7:0]  t2Count;
    logic [15:0] t1Period;
    int          mismatches, check_count, cyc, k;

    dtpc_timers dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .externalCountPin(extPin),
        .touchKeyOscillator(tkOsc), .capturePin(capPin), .timer0OverflowFlag(t0Flag),
        .timer1OverflowFlag(t1Flag), .timer2Count(t2Count), .timer1Period(t1Period)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;

    task automatic give_verdict();
        $display("mismatches %0d, checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chkr(input logic [15:0] got, input int lo, input int hi);
        check_count++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            mismatches++;
            $display("Error at %0t: got %0d, expected %0d to %0d", $time, got, lo, hi);
        end
    endtask

    task automatic hang();
        mismatches++;
        $display("Error at %0t: bus answer never came", $time);
        give_verdict();
    endtask

    // Handshakes are judged at the rising edge, on the values standing before it
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        int         n;
        logic       done;
        logic [1:0] r;
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 40 && !done; n++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            done = bvalid;
            r    = bresp;
        end
        if (!done) hang();
        chk(r, er);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
        int   n;
        logic done;
        araddr  <= a;
        arvalid <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 40 && !done; n++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            done = rvalid;
            v    = rdata;
            r    = rresp;
        end
        if (!done) hang();
    endtask

    task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
        logic [1:0] r;
        rd(a, v0, r);
        chk(v0[15:0], {8'h00, exp});
        chk(r, er);
    endtask

    // Count advance over a window, one count expected per dv clocks
    task automatic rate(input logic [11:0] a, input int w, input int dv);
        logic [1:0] r;
        logic [7:0] d;
        int         c;
        rd(a, v0, r);
        c = cyc;
        repeat (w) @(posedge sys_clk);
        rd(a, v1, r);
        c = (cyc - c) / dv;
        d = v1[7:0] - v0[7:0];
        chkr(d, c - (c > 0), c + (c > 0));
    endtask

    // Nine toggles from low: five rising and four falling edges
    task automatic edges(input logic [7:0] m, input logic tk, input logic [7:0] exp);
        logic [1:0] r;
        logic [7:0] d;
        wr(12'h108, m, 2'h0);
        rd(12'h004, v0, r);
        repeat (9) begin
            if (tk) tkOsc <= ~tkOsc;
            else extPin <= ~extPin;
            repeat (4) @(posedge sys_clk);
        end
        rd(12'h004, v1, r);
        d = v1[7:0] - v0[7:0];
        chk(d, exp);
        wr(12'h108, 8'h00, 2'h0);
        {tkOsc, extPin} <= 2'b00;
    endtask

    initial begin
        // Response ready stays high: back-to-back calls never re-drive it
        {reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h05;
        {extPin, tkOsc, capPin} = 3'h0;
        {awaddr, araddr, wdata} = 56'h0;
        mismatches = 0;
        check_count = 0;
        cyc = 0;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        rdc(12'h048, 8'h10, 2'h0);
        rdc(12'h108, 8'h00, 2'h0);
        rdc(12'h03c, 8'h00, 2'h2);
        wr(12'h03c, 8'h55, 2'h2);
        wr(12'h048, 8'h00, 2'h0);
        repeat (10) @(posedge sys_clk);
        wr(12'h048, 8'h10, 2'h0);
        // Zeroing lands one edge after the hold bit is written
        @(posedge sys_clk);
        chk(t2Count, 16'h0);
        wr(12'h048, 8'h18, 2'h0);
        rdc(12'h028, 8'hff, 2'h0);
        rdc(12'h02c, 8'hff, 2'h0);
        wr(12'h048, 8'h1e, 2'h0);
        rdc(12'h02c, 8'hff, 2'h0);
        wr(12'h048, 8'h16, 2'h0);
        rdc(12'h028, 8'h00, 2'h0);
        wr(12'h028, 8'h34, 2'h0);
        wr(12'h02c, 8'h12, 2'h0);
        rdc(12'h028, 8'h00, 2'h0);
        rdc(12'h02c, 8'h00, 2'h0);
        wr(12'h048, 8'h18, 2'h0);
        chk(t1Flag, 16'h0);
        wr(12'h048, 8'h10, 2'h0);
        rdc(12'h02c, 8'h12, 2'h0);
        chk(t1Flag, 16'h1);
        wr(12'h024, 8'h30, 2'h0);
        chk(t1Flag, 16'h1);
        wr(12'h024, 8'h00, 2'h0);
        chk(t1Flag, 16'h0);
        wr(12'h048, 8'h12, 2'h0);
        rate(12'h028, 50, 1 << 20);
        wr(12'h048, 8'h10, 2'h0);
        rate(12'h028, 100, 2);
        wr(12'h130, 8'h01, 2'h0);
        rate(12'h028, 100, 1);
        wr(12'h048, 8'h11, 2'h0);
        wr(12'h004, 8'hfe, 2'h0);
        rate(12'h004, 50, 1 << 20);
        wr(12'h024, 8'h00, 2'h0);
        chk(t0Flag, 16'h0);
        wr(12'h048, 8'h10, 2'h0);
        repeat (10) @(posedge sys_clk);
        chk(t0Flag, 16'h1);
        edges(8'h10, 1'b0, 8'h05);
        edges(8'h30, 1'b0, 8'h04);
        wr(12'h134, 8'h40, 2'h0);
        edges(8'h10, 1'b1, 8'h05);
        edges(8'h30, 1'b1, 8'h04);
        edges(8'h10, 1'b0, 8'h00);
        wr(12'h108, 8'h40, 2'h0);
        rate(12'h004, 60, 1 << 20);
        wr(12'h108, 8'hc0, 2'h0);
        rate(12'h004, 100, 2);
        capPin <= 1'b1;
        wr(12'h108, 8'h40, 2'h0);
        rate(12'h004, 100, 2);
        capPin <= 1'b0;
        for (k = 0; k < 10; k++) begin
            wr(12'h108, (k < 9) ? 8'(k) : 8'h0f, 2'h0);
            rate(12'h004, 12 << k, 2 << ((k < 8) ? k : 8));
        end
        wr(12'h028, 8'h00, 2'h0);
        wr(12'h02c, 8'h00, 2'h0);
        wr(12'h130, 8'h02, 2'h0);
        capPin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        capPin <= 1'b0;
        repeat (196) @(posedge sys_clk);
        capPin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chkr(t1Period, 99, 101);
        give_verdict();
    end
endmodule
